// ==== rtl/imusc_pkg.sv ====
package imusc_pkg;
    // ***********************************************
    // Register offsets (byte addresses of low bytes)
    // ***********************************************
    localparam logic [6:0] ADDR_MISC = 7'h34;
    localparam logic [6:0] ADDR_DIAG = 7'h3c;
    localparam logic [6:0] ADDR_CMD = 7'h3e;
    localparam logic [6:0] ADDR_LOT_LO = 7'h52;
    localparam logic [6:0] ADDR_LOT_HI = 7'h54;
    localparam logic [6:0] ADDR_PART = 7'h56;
    localparam logic [6:0] ADDR_SERIAL = 7'h58;
    localparam logic [6:0] ADDR_BKCNT = 7'h5a;

    // ***********************************************
    // Field positions and reset values
    // ***********************************************
    localparam logic [15:0] MISC_RST = 16'h0006;
    localparam logic [15:0] MISC_WMASK = 16'h0c47;
    localparam logic [15:0] MISC_TESTS = 16'h0c00;
    localparam int MISC_CKSUM = 11;
    localparam int MISC_SELF = 10;
    localparam int MISC_POP = 6;
    localparam int MISC_DR_EN = 2;
    localparam int MISC_DR_POL = 1;
    localparam int MISC_DR_SEL = 0;
    localparam int CMD_RESET = 7;
    localparam int CMD_BACKUP = 3;
    localparam int CMD_RESTORE = 1;
    localparam int CMD_BIAS = 0;
    localparam int DIAG_ST_LO = 10;
    localparam int DIAG_ALM2 = 9;
    localparam int DIAG_ALM1 = 8;
    localparam int DIAG_CKSUM = 6;
    localparam int DIAG_SELF = 5;
    localparam int DIAG_OVR = 4;
    localparam int DIAG_SPI = 3;
    localparam int DIAG_FLASH = 2;
    localparam int DIAG_SUPPLY = 0;
    localparam logic [15:0] DIAG_RST = 16'h0000;
    localparam logic [11:0] SERIAL_MASK = 12'hfff;
    localparam int SPI_WR_BIT = 15;

    // ***********************************************
    // Timing
    // ***********************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int BACKUP_MS = 75;
    localparam int CKSUM_MS = 20;
    localparam int SELF_MS = 10;
    localparam int FUNC_MS = 1;
    localparam int BACKUP_CYC = CLK_HZ / 1000 * BACKUP_MS;
    localparam int CKSUM_CYC = CLK_HZ / 1000 * CKSUM_MS;
    localparam int SELF_CYC = CLK_HZ / 1000 * SELF_MS;
    localparam int FUNC_CYC = CLK_HZ / 1000 * FUNC_MS;
    localparam int TMR_W = 21;

    // Command sequencer and test sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_FUNC = 2'b01, ST_BACKUP = 2'b11, ST_RESET = 2'b10
    } imusc_seq_t;
    typedef enum logic [1:0] {
        TS_IDLE = 2'b00, TS_CKSUM = 2'b01, TS_SELF = 2'b11
    } imusc_test_t;
endpackage

// ==== rtl/imusc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Command trigger bits start function, self-clear
// - Command bit 7 performs software reset
// - Reset reloads controls from backup as it ends
// - Command bit 3 copies settings to flash
// - Restore and bias correction followed by backup
// - Sixteen-bit counter counts every flash backup
// - Read-only part code register
// - Two lot registers form 32-bit code
// - Serial number in low 12 bits
// - Control bit 10 runs self-test, reports bit 5
// - Diagnostic bits 15:10 flag per-sensor failures
// - Data ready enable, polarity, line select
// - Control bit 6 enables percussion correction
// - Diagnostic read returns flags, then clears
// - Persisting error resets flag next sample
// - Supply flag clears itself when supply good
// - Bit 3 flags non-multiple-of-16 clock frames
// - Alarms, overrange, flash failure flag bits
// - Control bit 11 checksum test, 20 ms
// - Serial byte writes, low/high byte addresses
// - Flash backup takes 75 ms
module imusc_top
    import imusc_pkg::*;
#(
    parameter int BACKUP_CYCLES = BACKUP_CYC,
    parameter int CKSUM_CYCLES = CKSUM_CYC,
    parameter int SELF_CYCLES = SELF_CYC,
    parameter int FUNC_CYCLES = FUNC_CYC,
    parameter logic [15:0] PART_CODE = 16'h1234, // arbitrary value
    parameter logic [15:0] LOT_LOW = 16'h0001, // arbitrary value
    parameter logic [15:0] LOT_HIGH = 16'h0002, // arbitrary value
    parameter logic [11:0] SERIAL = 12'h001 // arbitrary value
) (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Serial link, mode 3
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_din,
    output logic o_dout,
    // Sensor status inputs
    input wire logic i_sample_tgl,
    input wire logic i_data_valid,
    input wire logic i_supply_fault,
    input wire logic [1:0] i_alarm,
    input wire logic i_overrange,
    input wire logic [5:0] i_self_fail,
    input wire logic i_cksum_bad,
    // Data ready lines
    output logic o_io_line_one,
    output logic o_io_line_one_oe,
    output logic o_io_line_two,
    output logic o_io_line_two_oe,
    // Block status
    output logic o_pop_enable,
    output logic o_self_test_active,
    output logic o_data_run
);
    // ***********************************************
    // Link domain: receive and transmit shifters
    // ***********************************************
    logic in_frame;
    logic [3:0] bit_cnt;
    logic [14:0] rx_sh;
    logic [15:0] rx_word;
    logic rx_tgl;
    logic partial;
    logic [14:0] tx_sh;
    logic [15:0] tx_word;
    wire frm_rst_n = i_nrst & ~i_cs_n;
    wire [3:0] cnt_base = in_frame ? bit_cnt : 4'h0;
    wire [3:0] next_bit_cnt = cnt_base + 4'h1;
    wire bit_done = (cnt_base == 4'hf);

    // Frame marker drops while select is high
    always_ff @(posedge i_sclk or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // Count edges; count survives frame end so the remainder can be judged
    always_ff @(posedge i_sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            bit_cnt <= 4'h0;
            rx_sh <= 15'h0000;
            rx_word <= 16'h0000;
            rx_tgl <= 1'b0;
            partial <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            rx_sh <= {rx_sh[13:0], i_din};
            partial <= (next_bit_cnt != 4'h0);
            if (bit_done) begin
                rx_word <= {rx_sh, i_din};
                rx_tgl <= ~rx_tgl;
            end
        end
    end

    // Answer word loads at each word start; host stalls between frames
    always_ff @(negedge i_sclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_sh <= 15'h0000;
            o_dout <= 1'b0;
        end else if (cnt_base == 4'h0) begin
            o_dout <= tx_word[15];
            tx_sh <= tx_word[14:0];
        end else begin
            o_dout <= tx_sh[14];
            tx_sh <= {tx_sh[13:0], 1'b0};
        end
    end

    // ***********************************************
    // Crossing into the system domain
    // ***********************************************
    localparam int SYNC_W = 17;
    // Select idles high; resetting its copy high avoids a false frame end
    localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b1, {(SYNC_W-1){1'b0}}};
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic rx_tgl_d;
    logic cs_d;
    logic smp_d;
    wire [SYNC_W-1:0] async_in = {i_cs_n, rx_tgl, partial, i_sample_tgl, i_data_valid,
        i_supply_fault, i_alarm, i_overrange, i_self_fail, i_cksum_bad, 1'b0};
    wire s_cs_n = sync2[16];
    wire s_rx_tgl = sync2[15];
    wire s_partial = sync2[14];
    wire s_smp = sync2[13];
    wire s_valid = sync2[12];
    wire s_supply = sync2[11];
    wire [1:0] s_alarm = sync2[10:9];
    wire s_ovr = sync2[8];
    wire [5:0] s_self_fail = sync2[7:2];
    wire s_cksum_bad = sync2[1];

    // Two-stage synchroniser, edge history on the second stage only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
            rx_tgl_d <= 1'b0;
            cs_d <= 1'b1;
            smp_d <= 1'b0;
        end else begin
            sync1 <= async_in;
            sync2 <= sync1;
            rx_tgl_d <= s_rx_tgl;
            cs_d <= s_cs_n;
            smp_d <= s_smp;
        end
    end

    // ***********************************************
    // Register access decode
    // ***********************************************
    logic [15:0] misc;
    logic [15:0] flash_misc;
    logic [15:0] diag;
    logic [15:0] bk_cnt;
    logic [3:0] pend;
    logic bk_fail;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] ttmr;
    imusc_seq_t state;
    imusc_test_t tstate;
    // Word is quasi-static here: it changes only 16 link edges later
    wire rx_evt = s_rx_tgl ^ rx_tgl_d;
    wire wr = rx_word[SPI_WR_BIT];
    wire [6:0] addr = rx_word[14:8];
    wire [7:0] wdata = rx_word[7:0];
    wire [6:0] reg_addr = {addr[6:1], 1'b0};
    // Only control and command decode writes
    wire misc_wr_lo = rx_evt & wr & (addr == ADDR_MISC);
    wire misc_wr_hi = rx_evt & wr & (addr == (ADDR_MISC | 7'h01));
    wire cmd_wr = rx_evt & wr & (addr == ADDR_CMD);
    wire diag_rd = rx_evt & ~wr & (reg_addr == ADDR_DIAG);
    wire smp_evt = s_smp ^ smp_d;
    wire spi_err = s_cs_n & ~cs_d & s_partial;

    wire [15:0] rd_data =
        (reg_addr == ADDR_MISC) ? misc :
        (reg_addr == ADDR_DIAG) ? diag :
        (reg_addr == ADDR_LOT_LO) ? LOT_LOW :
        (reg_addr == ADDR_LOT_HI) ? LOT_HIGH :
        (reg_addr == ADDR_PART) ? PART_CODE :
        (reg_addr == ADDR_SERIAL) ? {4'h0, SERIAL & SERIAL_MASK} :
        (reg_addr == ADDR_BKCNT) ? bk_cnt : 16'h0000;

    // ***********************************************
    // Command sequencer
    // ***********************************************
    wire seq_done = (state != ST_IDLE) && (tmr == {TMR_W{1'b0}});
    wire reset_done = seq_done && (state == ST_RESET);
    wire func_done = seq_done && (state == ST_FUNC);
    wire bk_done = seq_done && (state == ST_BACKUP);
    wire [3:0] pend_set = cmd_wr ?
        {wdata[CMD_RESET], wdata[CMD_BACKUP], wdata[CMD_RESTORE], wdata[CMD_BIAS]} : 4'h0;
    imusc_seq_t next_state;
    logic [TMR_W-1:0] next_tmr;
    logic [3:0] pend_clr;

    always_comb begin
        next_state = state;
        next_tmr = (tmr != {TMR_W{1'b0}}) ? tmr - 1'b1 : tmr;
        pend_clr = 4'h0;
        unique case (state)
            ST_IDLE: begin
                if (pend[3]) begin
                    next_state = ST_RESET;
                    next_tmr = TMR_W'(FUNC_CYCLES - 1);
                end else if (pend[1] | pend[0]) begin
                    next_state = ST_FUNC;
                    next_tmr = TMR_W'(FUNC_CYCLES - 1);
                end else if (pend[2]) begin
                    next_state = ST_BACKUP;
                    next_tmr = TMR_W'(BACKUP_CYCLES - 1);
                end
            end
            ST_FUNC: begin
                if (seq_done) begin
                    pend_clr = pend[1] ? 4'b0010 : 4'b0001;
                    next_state = ST_BACKUP;
                    next_tmr = TMR_W'(BACKUP_CYCLES - 1);
                end
            end
            ST_BACKUP: begin
                if (seq_done) begin
                    pend_clr = 4'b0100;
                    next_state = ST_IDLE;
                end
            end
            ST_RESET: begin
                if (seq_done) begin
                    pend_clr = 4'b1111;
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Sequencer state; a new trigger beats its own clear
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            tmr <= {TMR_W{1'b0}};
            pend <= 4'h0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            pend <= (pend & ~pend_clr) | pend_set;
        end
    end

    // ***********************************************
    // Test sequencer
    // ***********************************************
    wire test_done = (tstate != TS_IDLE) && (ttmr == {TMR_W{1'b0}});
    wire cksum_done = test_done && (tstate == TS_CKSUM);
    wire self_done = test_done && (tstate == TS_SELF);
    imusc_test_t next_tstate;
    logic [TMR_W-1:0] next_ttmr;

    // Checksum first when both are requested
    always_comb begin
        next_tstate = tstate;
        next_ttmr = (ttmr != {TMR_W{1'b0}}) ? ttmr - 1'b1 : ttmr;
        unique case (tstate)
            TS_IDLE: begin
                if (misc[MISC_CKSUM]) begin
                    next_tstate = TS_CKSUM;
                    next_ttmr = TMR_W'(CKSUM_CYCLES - 1);
                end else if (misc[MISC_SELF]) begin
                    next_tstate = TS_SELF;
                    next_ttmr = TMR_W'(SELF_CYCLES - 1);
                end
            end
            TS_CKSUM, TS_SELF: begin
                if (test_done) begin
                    next_tstate = TS_IDLE;
                end
            end
            default: begin
                next_tstate = TS_IDLE;
            end
        endcase
        if (reset_done) begin
            next_tstate = TS_IDLE;
        end
    end

    // ***********************************************
    // Control register and backup copy
    // ***********************************************
    logic [15:0] next_misc;

    // Bits 9:8 never stored, host keeps them zero anyway
    always_comb begin
        next_misc = misc;
        if (misc_wr_lo) begin
            next_misc[7:0] = wdata & MISC_WMASK[7:0];
        end
        if (misc_wr_hi) begin
            next_misc[15:8] = wdata & MISC_WMASK[15:8];
        end
        if (cksum_done) begin
            next_misc[MISC_CKSUM] = 1'b0;
        end
        if (self_done) begin
            next_misc[MISC_SELF] = 1'b0;
        end
        if (func_done && pend[1]) begin
            next_misc = MISC_RST;
        end
        // Reload from backup in the same cycle output resumes
        if (reset_done) begin
            next_misc = flash_misc;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            misc <= MISC_RST;
            flash_misc <= MISC_RST;
            bk_cnt <= 16'h0000;
            bk_fail <= 1'b0;
            tstate <= TS_IDLE;
            ttmr <= {TMR_W{1'b0}};
        end else begin
            misc <= next_misc;
            tstate <= next_tstate;
            ttmr <= next_ttmr;
            bk_fail <= (state == ST_BACKUP) & ~bk_done & (bk_fail | s_supply);
            if (bk_done) begin
                // Test triggers are not kept, a reset must not rerun them
                flash_misc <= misc & ~MISC_TESTS;
                bk_cnt <= bk_cnt + 16'h0001;
            end
        end
    end

    // ***********************************************
    // Diagnostic flags
    // ***********************************************
    logic [15:0] diag_set;
    logic [15:0] next_diag;

    always_comb begin
        diag_set = 16'h0000;
        if (smp_evt) begin
            diag_set[DIAG_ALM2] = s_alarm[1];
            diag_set[DIAG_ALM1] = s_alarm[0];
            diag_set[DIAG_OVR] = s_ovr;
            diag_set[DIAG_SUPPLY] = s_supply;
        end
        diag_set[DIAG_SPI] = spi_err;
        diag_set[DIAG_FLASH] = bk_done & (bk_fail | s_supply);
        diag_set[DIAG_CKSUM] = cksum_done & s_cksum_bad;
        if (self_done) begin
            diag_set[15:DIAG_ST_LO] = s_self_fail;
            diag_set[DIAG_SELF] = |s_self_fail;
        end
    end

    // Read clears, set wins, supply flag self-clears
    always_comb begin
        next_diag = (diag_rd || reset_done) ? DIAG_RST : diag;
        next_diag = next_diag | diag_set;
        if (!s_supply) begin
            next_diag[DIAG_SUPPLY] = 1'b0;
        end
    end

    // Flags and the answer word for the next frame
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            diag <= DIAG_RST;
            tx_word <= 16'h0000;
        end else begin
            diag <= next_diag;
            if (rx_evt) begin
                tx_word <= wr ? 16'h0000 : rd_data;
            end
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    // Data ready level and line choice
    wire dr_level = misc[MISC_DR_POL] ? s_valid : ~s_valid;
    wire dr_one = misc[MISC_DR_EN] & ~misc[MISC_DR_SEL];
    wire dr_two = misc[MISC_DR_EN] & misc[MISC_DR_SEL];

    // Correction enable follows control bit 6
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_io_line_one <= 1'b0;
            o_io_line_one_oe <= 1'b0;
            o_io_line_two <= 1'b0;
            o_io_line_two_oe <= 1'b0;
            o_pop_enable <= 1'b0;
            o_self_test_active <= 1'b0;
            o_data_run <= 1'b0;
        end else begin
            o_io_line_one <= dr_one & dr_level;
            o_io_line_one_oe <= dr_one;
            o_io_line_two <= dr_two & dr_level;
            o_io_line_two_oe <= dr_two;
            o_pop_enable <= misc[MISC_POP];
            o_self_test_active <= (next_tstate == TS_SELF);
            o_data_run <= (next_state != ST_RESET);
        end
    end

    // ***********************************************
    // Assertions
    // ***********************************************
    a_cmd_reads_zero: assert property (@(posedge i_clk) disable iff (!i_nrst)
        rx_evt && !wr && reg_addr == ADDR_CMD |=> tx_word == 16'h0000)
        else $error("command register read not zero");
    a_backup_counts: assert property (@(posedge i_clk) disable iff (!i_nrst)
        bk_done |=> bk_cnt == $past(bk_cnt) + 16'h0001 && state == ST_IDLE)
        else $error("backup counter did not step");
    a_backup_length: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(state == ST_BACKUP) |-> tmr == TMR_W'(BACKUP_CYCLES - 1))
        else $error("backup timer load wrong");
    a_func_then_bk: assert property (@(posedge i_clk) disable iff (!i_nrst)
        func_done |=> state == ST_BACKUP ##1 state == ST_BACKUP)
        else $error("function not followed by backup");
    a_reset_reload: assert property (@(posedge i_clk) disable iff (!i_nrst)
        reset_done |=> misc == $past(flash_misc) && o_data_run)
        else $error("reset did not reload controls");
    a_ro_unchanged: assert property (@(posedge i_clk) disable iff (!i_nrst)
        rx_evt && wr && reg_addr == ADDR_BKCNT && !bk_done |=> $stable(bk_cnt))
        else $error("read-only counter written");
    a_diag_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
        diag_rd && diag_set == 16'h0000 |=> diag == 16'h0000)
        else $error("diagnostic read did not clear");
    a_supply_auto: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !s_supply |=> !diag[DIAG_SUPPLY])
        else $error("supply flag stuck");
    a_cksum_ends: assert property (@(posedge i_clk) disable iff (!i_nrst)
        cksum_done && !misc_wr_hi |=> !misc[MISC_CKSUM] && diag[DIAG_CKSUM] == ($past(s_cksum_bad)
            || ($past(diag[DIAG_CKSUM]) && !$past(diag_rd) && !$past(reset_done))))
        else $error("checksum end wrong");
    a_spi_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
        spi_err && !reset_done |=> diag[DIAG_SPI])
        else $error("partial frame not flagged");
    a_self_fail: assert property (@(posedge i_clk) disable iff (!i_nrst)
        self_done && s_self_fail != 6'h00 && !reset_done |=> diag[DIAG_SELF] && !misc[MISC_SELF])
        else $error("self-test result missing");
    a_dr_line_one: assert property (@(posedge i_clk) disable iff (!i_nrst)
        dr_one |=> o_io_line_one_oe && o_io_line_one == $past(dr_level))
        else $error("data ready line one wrong");
endmodule
`default_nettype wire

// ==== test/imusc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Host link master model
// ****
module imusc_host (
    // Link
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_din,
    input wire logic i_dout
);
    // Clock parked high between frames
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_din = 1'b0;
    end
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        #7 o_cs_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            #15 o_sclk = 1'b0;
            o_din = w[15 - k];
            #15 o_sclk = 1'b1;
            r = {r[14:0], i_dout};
        end
        #20 o_cs_n = 1'b1;
        // No stale bit left on the released line
        o_din = ~o_din;
        // Stall well over eight system clocks
        #500;
    endtask
    // One byte a write word, low then high
    task automatic wr16(input logic [6:0] a, input logic [15:0] v);
        logic [15:0] r;
        frame({1'b1, a, v[7:0]}, 16, r);
        frame({1'b1, a | 7'h01, v[15:8]}, 16, r);
    endtask
    // Answer comes in the following word
    task automatic rd16(input logic [6:0] a, output logic [15:0] v);
        logic [15:0] r;
        frame({1'b0, a, 8'h00}, 16, r);
        frame(16'h0000, 16, v);
    endtask
endmodule
`default_nettype wire

// ==== test/tb_imusc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_imusc_top;
    import imusc_pkg::*;
    localparam int BK = 200;
    localparam int FN = 100;
    localparam int TS = 100;
    logic i_clk, i_nrst, sclk, cs_n, din, dout, tgl, dv, sup, ovr, ck;
    logic l1, l1e, l2, l2e, pop, sta, run;
    logic [1:0] alm;
    logic [5:0] sf;
    logic [15:0] v, e;
    int bad_count, n_checks, seed;
    // Identity values are arbitrary; serial one below its top value
    imusc_top #(.BACKUP_CYCLES(BK), .CKSUM_CYCLES(TS), .SELF_CYCLES(TS),
        .FUNC_CYCLES(FN), .PART_CODE(16'h5a5a), .LOT_LOW(16'h1357),
        .LOT_HIGH(16'h2468), .SERIAL(12'hffe)) i_imusc_top (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .o_dout(dout), .i_sample_tgl(tgl), .i_data_valid(dv),
        .i_supply_fault(sup), .i_alarm(alm), .i_overrange(ovr),
        .i_self_fail(sf), .i_cksum_bad(ck), .o_io_line_one(l1),
        .o_io_line_one_oe(l1e), .o_io_line_two(l2), .o_io_line_two_oe(l2e),
        .o_pop_enable(pop), .o_self_test_active(sta), .o_data_run(run));
    imusc_host u_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));
    // 25 MHz system clock
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input string s, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic rc(input string s, input logic [6:0] a, input logic [15:0] x);
        logic [15:0] r;
        u_host.rd16(a, r);
        chk(s, r, x);
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Self-test outcome as the flag register shows it
    function automatic logic [15:0] diag_st(input logic [5:0] f);
        return {f, 4'h0, |f, 5'h00};
    endfunction
    // Hang guard
    initial begin
        #2_000_000;
        bad_count++;
        wrap_up();
    end
    // ****
    // Main sequence
    // ****
    initial begin
        seed = 39;
        bad_count = 0;
        n_checks = 0;
        {i_nrst, tgl, dv, sup, ovr, ck, alm, sf} = '0;
        clk(2);
        i_nrst <= 1'b1;
        clk(4);
        rc("misc", ADDR_MISC, MISC_RST);
        rc("diag", ADDR_DIAG, DIAG_RST);
        rc("cmd", ADDR_CMD, 16'h0000);
        rc("unmapped", 7'h60, 16'h0000);
        rc("lot lo", ADDR_LOT_LO, 16'h1357);
        rc("lot hi", ADDR_LOT_HI, 16'h2468);
        rc("serial", ADDR_SERIAL, 16'h0ffe);
        u_host.wr16(ADDR_PART, 16'hffff);
        u_host.wr16(ADDR_BKCNT, 16'hffff);
        rc("part", ADDR_PART, 16'h5a5a);
        rc("count", ADDR_BKCNT, 16'h0000);
        // Every data ready setting; dropped bits other than 9:8 sent as ones
        for (int c = 0; c < 8; c++) begin
            e = 16'(c) | (16'($random(seed)) & 16'h0040);
            // Bits 9:8 always sent as zero
            u_host.wr16(ADDR_MISC, e | 16'hf0b8);
            clk(1);
            dv <= 1'($random(seed));
            clk(6);
            rc("misc", ADDR_MISC, e);
            chk("pop", 16'(pop), 16'(e[6]));
            chk("dr oe", 16'({l2e, l1e}), 16'({e[2] & e[0], e[2] & ~e[0]}));
            if (e[2]) chk("dr lvl", 16'(e[0] ? l2 : l1), 16'(e[1] ? dv : !dv));
        end
        // Backup, then reset reloads the backed-up copy
        u_host.wr16(ADDR_MISC, 16'h0044);
        u_host.wr16(ADDR_CMD, 16'h0008);
        rc("count", ADDR_BKCNT, 16'h0000);
        clk(BK);
        rc("count", ADDR_BKCNT, 16'h0001);
        rc("cmd", ADDR_CMD, 16'h0000);
        u_host.wr16(ADDR_MISC, 16'h0000);
        u_host.wr16(ADDR_CMD, 16'h0080);
        chk("run", 16'(run), 16'h0000);
        clk(FN + 10);
        chk("run", 16'(run), 16'h0001);
        rc("misc", ADDR_MISC, 16'h0044);
        // Bias correction and restore each end in a backup
        for (int k = 0; k < 2; k++) begin
            u_host.wr16(ADDR_CMD, 16'(k + 1));
            clk(FN + BK + 10);
            rc("count", ADDR_BKCNT, 16'(k + 2));
        end
        rc("misc", ADDR_MISC, MISC_RST);
        // Checksum then self-test with random failures
        clk(1);
        sf <= 6'($random(seed)) | 6'h10; // At least one failing sensor
        ck <= 1'b1;
        u_host.wr16(ADDR_MISC, 16'h0c06);
        clk(TS + 20);
        chk("st run", 16'(sta), 16'h0001);
        clk(TS);
        rc("misc", ADDR_MISC, MISC_RST);
        rc("diag", ADDR_DIAG, diag_st(sf) | 16'h0040);
        // Sampled flags; supply fault spoils a backup
        clk(1);
        {alm, ovr, sup} <= 4'hf;
        tgl <= ~tgl;
        u_host.wr16(ADDR_CMD, 16'h0008);
        clk(BK + 10);
        {ovr, sup} <= 2'b00;
        clk(6);
        rc("diag", ADDR_DIAG, 16'h0314);
        rc("diag", ADDR_DIAG, 16'h0000);
        clk(1);
        tgl <= ~tgl;
        clk(6);
        rc("diag", ADDR_DIAG, 16'h0300);
        // Short frame of ten edges
        u_host.frame(16'h0000, 10, v);
        rc("diag", ADDR_DIAG, 16'h0008);
        wrap_up();
    end
endmodule
`default_nettype wire
